// File: hdl/dmr_pkg.sv
// Overview of operation
// - read inversion enable picks read latency column
// - write latency set bit picks set A or B
// - read auto precharge waits read-to-precharge clocks
// - write auto precharge waits write-recovery clocks
// - burst length 32 adds eight read precharge clocks
// - postamble bit: half clock default, else 1.5
// - register access uses write set-point copy
// - device operates from operating set-point copy
// - repair protect sticky; blocks repair entry writes
// - refresh-rate field encodes eight temperature states
// - refresh-rate msb set means above 85 degrees
// - derating needed reports refresh code 110
// - codes 000 and 111 flag unsafe operation
// - update flag sets on change, read clears
// - update flag zero at reset; rate valid after init
// - temperature register writes touch bits 6..3 only
// - thermal offset: none, five, ten, reserved
// - repair entry bit enters and exits repair mode
// - self refresh abort defaults off
package dmr_pkg;
   // ---------------------------------------------------------------
   // register addresses
   // ---------------------------------------------------------------
   localparam logic [5:0] ADDR_LATENCY = 6'h02;
   localparam logic [5:0] ADDR_IO_CONFIG_ONE = 6'h03;
   localparam logic [5:0] ADDR_TEMPERATURE_REFRESH = 6'h04;
   localparam logic [5:0] ADDR_VENDOR_IDENTITY = 6'h05;
   localparam logic [5:0] ADDR_SET_POINT = 6'h0D;
   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int BIT_PULLUP_CAL = 0;
   localparam int BIT_WR_POSTAMBLE = 1;
   localparam int BIT_REPAIR_PROTECT = 2;
   localparam int BIT_INV_RD = 6;
   localparam int BIT_INV_WR = 7;
   localparam int BIT_SELF_REFRESH_ABORT = 3;
   localparam int BIT_REPAIR_ENTRY = 4;
   localparam int BIT_UPDATE_FLAG = 7;
   localparam int BIT_WL_SET = 6;
   localparam int BIT_WR_SP = 6;
   localparam int BIT_OP_SP = 7;
   localparam logic [7:0] IO_CONFIG_RESET = 8'h31; // drive /6, cal 0.5
   localparam logic [7:0] TEMP_WR_MASK = 8'h78;
   localparam logic [2:0] RATE_NOMINAL = 3'h3;
   localparam logic [2:0] RATE_DERATE = 3'h6;
   localparam logic [2:0] RATE_LOW_LIMIT = 3'h0;
   localparam logic [2:0] RATE_HIGH_LIMIT = 3'h7;
   localparam logic [7:0] LATENCY_RESET = 8'h00;
   localparam logic [5:0] BL32_EXTRA = 6'h08;
   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      DMR_CMD_NONE = 2'h0,
      DMR_CMD_WRITE = 2'h1,
      DMR_CMD_READ = 2'h2
   } dmr_cmd_e;
endpackage

// File: hdl/dmr_sp_if.sv
`timescale 1ns/100ps
// set-point duplicated storage port
interface dmr_sp_if;
   logic wr_en;
   logic wr_sel;
   logic [7:0] wr_data;
   logic rd_sel;
   logic op_sel;
   logic [7:0] rd_data;
   logic [7:0] op_data;
   modport owner (output wr_en, wr_sel, wr_data, rd_sel, op_sel, input rd_data, op_data);
   modport store (input wr_en, wr_sel, wr_data, rd_sel, op_sel, output rd_data, op_data);
endinterface

// File: hdl/dmr_sp_store.sv
`timescale 1ns/100ps
// two physical copies of one mode register
module dmr_sp_store #(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // access
   dmr_sp_if.store sp
);
   logic [7:0] copy_r [2];

   // ---------------------------------------------------------------
   // copy storage, written copy chosen by write set point
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_copy
         always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               copy_r[g] <= RESET_VAL;
            end else if (sp.wr_en && (sp.wr_sel == 1'(g))) begin
               copy_r[g] <= sp.wr_data;
            end
         end
      end
   endgenerate

   // read copy and operating copy
   assign sp.rd_data = copy_r[sp.rd_sel];
   assign sp.op_data = copy_r[sp.op_sel];
endmodule

// File: hdl/dmr_regs.sv
`timescale 1ns/100ps
// mode register bank: latency, io configuration, temperature, identity
module dmr_regs #(
   parameter logic [7:0] VENDOR_ID = 8'h5A // arbitrary value
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // mode register command port
   input wire logic [1:0] cmd_i,
   input wire logic [5:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   // temperature sensor
   input wire logic init_done_i,
   input wire logic [2:0] sensor_rate_i,
   input wire logic sensor_derate_i,
   // auto precharge requests
   input wire logic rd_ap_i,
   input wire logic wr_ap_i,
   input wire logic burst32_i,
   output logic precharge_o,
   // operating configuration
   output logic [7:0] op_io_config_o,
   output logic [3:0] read_latency_o,
   output logic [3:0] write_latency_o,
   output logic [4:0] read_to_precharge_clocks_o,
   output logic [5:0] write_recovery_clocks_o,
   output logic repair_protect_o,
   output logic repair_entry_o,
   output logic self_refresh_abort_o,
   output logic [1:0] thermal_offset_o,
   output logic [2:0] refresh_rate_o,
   output logic temp_update_flag_o,
   output logic over_85_o,
   output logic unsafe_temp_o
);
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   logic is_wr;
   logic is_rd;
   logic write_set_point_sel_r;
   logic operating_set_point_sel_r;
   logic [7:0] temp_ctrl_r;
   logic [2:0] rate_r;
   logic temp_update_flag_r;
   logic repair_protect_r;
   logic [6:0] pre_cnt_r;
   logic pre_busy_r;
   logic [6:0] pre_load;
   logic [4:0] rtp_sel;
   logic [5:0] wr_rec_sel;
   logic [7:0] lat_op;
   logic [7:0] io_op;
   logic [2:0] rate_nxt;

   assign is_wr = (dmr_pkg::dmr_cmd_e'(cmd_i) == dmr_pkg::DMR_CMD_WRITE);
   assign is_rd = (dmr_pkg::dmr_cmd_e'(cmd_i) == dmr_pkg::DMR_CMD_READ);

   // ---------------------------------------------------------------
   // duplicated latency and io configuration storage
   // ---------------------------------------------------------------
   dmr_sp_if lat_if ();
   dmr_sp_if io_if ();

   // write and read use write set point, operation uses operating one
   assign lat_if.wr_en = is_wr && (addr_i == dmr_pkg::ADDR_LATENCY);
   assign lat_if.wr_sel = write_set_point_sel_r;
   assign lat_if.wr_data = wdata_i;
   assign lat_if.rd_sel = write_set_point_sel_r;
   assign lat_if.op_sel = operating_set_point_sel_r;
   assign io_if.wr_en = is_wr && (addr_i == dmr_pkg::ADDR_IO_CONFIG_ONE);
   assign io_if.wr_sel = write_set_point_sel_r;
   assign io_if.rd_sel = write_set_point_sel_r;
   assign io_if.op_sel = operating_set_point_sel_r;
   // protect bit is stored in the copies as written and also sets the sticky flag
   assign io_if.wr_data = wdata_i;

   dmr_sp_store #(
      .RESET_VAL(dmr_pkg::LATENCY_RESET)
   ) u_lat (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .sp(lat_if.store)
   );

   dmr_sp_store #(
      .RESET_VAL(dmr_pkg::IO_CONFIG_RESET)
   ) u_io (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .sp(io_if.store)
   );

   assign lat_op = lat_if.op_data;
   assign io_op = io_if.op_data;

   // ---------------------------------------------------------------
   // set-point selection register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         write_set_point_sel_r <= 1'b0;
         operating_set_point_sel_r <= 1'b0;
      end else if (is_wr && (addr_i == dmr_pkg::ADDR_SET_POINT)) begin
         write_set_point_sel_r <= wdata_i[dmr_pkg::BIT_WR_SP];
         operating_set_point_sel_r <= wdata_i[dmr_pkg::BIT_OP_SP];
      end
   end

   // ---------------------------------------------------------------
   // sticky repair protection
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         repair_protect_r <= 1'b0;
      end else if (io_if.wr_en && wdata_i[dmr_pkg::BIT_REPAIR_PROTECT]) begin
         repair_protect_r <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // temperature register writable bits
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         temp_ctrl_r <= 8'h00;
      end else if (is_wr && (addr_i == dmr_pkg::ADDR_TEMPERATURE_REFRESH)) begin
         temp_ctrl_r <= wdata_i & dmr_pkg::TEMP_WR_MASK;
         if (repair_protect_r && wdata_i[dmr_pkg::BIT_REPAIR_ENTRY]) begin
            temp_ctrl_r[dmr_pkg::BIT_REPAIR_ENTRY] <= temp_ctrl_r[dmr_pkg::BIT_REPAIR_ENTRY];
         end
      end
   end

   // ---------------------------------------------------------------
   // refresh-rate tracking and update flag
   // ---------------------------------------------------------------
   always_comb begin
      rate_nxt = sensor_rate_i;
      if (sensor_derate_i) begin
         rate_nxt = dmr_pkg::RATE_DERATE;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rate_r <= dmr_pkg::RATE_NOMINAL;
      end else if (init_done_i) begin
         rate_r <= rate_nxt;
      end
   end

   // set beats clear when a change and a read coincide
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         temp_update_flag_r <= 1'b0;
      end else if (init_done_i && (rate_nxt != rate_r)) begin
         temp_update_flag_r <= 1'b1;
      end else if (is_rd && (addr_i == dmr_pkg::ADDR_TEMPERATURE_REFRESH)) begin
         temp_update_flag_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // latency decode from operating copy
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         read_latency_o <= 4'h0;
         write_latency_o <= 4'h0;
         read_to_precharge_clocks_o <= 5'h08;
         write_recovery_clocks_o <= 6'h06;
      end else begin
         // codes carry the column: bit 3 marks with-inversion / set B
         read_latency_o <= {io_op[dmr_pkg::BIT_INV_RD], lat_op[2:0]};
         write_latency_o <= {lat_op[dmr_pkg::BIT_WL_SET], lat_op[5:3]};
         read_to_precharge_clocks_o <= rtp_sel;
         write_recovery_clocks_o <= wr_rec_sel;
      end
   end

   // precharge delay per latency code
   always_comb begin
      case (lat_op[2:0])
         3'h4: rtp_sel = 5'h0A;
         3'h5: rtp_sel = 5'h0C;
         3'h6: rtp_sel = 5'h0E;
         3'h7: rtp_sel = 5'h10;
         default: rtp_sel = 5'h08;
      endcase
      case (lat_op[2:0])
         3'h1: wr_rec_sel = 6'h0A;
         3'h2: wr_rec_sel = 6'h10;
         3'h3: wr_rec_sel = 6'h14;
         3'h4: wr_rec_sel = 6'h18;
         3'h5: wr_rec_sel = 6'h1E;
         3'h6: wr_rec_sel = 6'h22;
         3'h7: wr_rec_sel = 6'h28;
         default: wr_rec_sel = 6'h06;
      endcase
   end

   // ---------------------------------------------------------------
   // auto precharge delay counter
   // ---------------------------------------------------------------
   always_comb begin
      pre_load = 7'h00;
      if (rd_ap_i) begin
         pre_load = {2'b00, read_to_precharge_clocks_o};
         if (burst32_i) begin
            pre_load = pre_load + {1'b0, dmr_pkg::BL32_EXTRA};
         end
      end else if (wr_ap_i) begin
         pre_load = {1'b0, write_recovery_clocks_o};
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pre_cnt_r <= 7'h00;
         pre_busy_r <= 1'b0;
         precharge_o <= 1'b0;
      end else begin
         precharge_o <= 1'b0;
         if (rd_ap_i || wr_ap_i) begin
            pre_cnt_r <= pre_load - 7'h01;
            pre_busy_r <= 1'b1;
         end else if (pre_busy_r) begin
            if (pre_cnt_r == 7'h01) begin
               precharge_o <= 1'b1;
               pre_busy_r <= 1'b0;
            end
            pre_cnt_r <= pre_cnt_r - 7'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // mode register read answer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_o <= 8'h00;
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= is_rd;
         if (is_rd) begin
            case (addr_i)
               dmr_pkg::ADDR_TEMPERATURE_REFRESH:
                  rdata_o <= {temp_update_flag_r, temp_ctrl_r[6:3], rate_r};
               dmr_pkg::ADDR_VENDOR_IDENTITY: rdata_o <= VENDOR_ID;
               dmr_pkg::ADDR_IO_CONFIG_ONE: rdata_o <= io_if.rd_data;
               dmr_pkg::ADDR_LATENCY: rdata_o <= lat_if.rd_data;
               default: rdata_o <= 8'h00;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // registered status outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         op_io_config_o <= dmr_pkg::IO_CONFIG_RESET;
         repair_protect_o <= 1'b0;
         repair_entry_o <= 1'b0;
         self_refresh_abort_o <= 1'b0;
         thermal_offset_o <= 2'h0;
         refresh_rate_o <= dmr_pkg::RATE_NOMINAL;
         temp_update_flag_o <= 1'b0;
         over_85_o <= 1'b0;
         unsafe_temp_o <= 1'b0;
      end else begin
         op_io_config_o <= io_op;
         repair_protect_o <= repair_protect_r;
         repair_entry_o <= temp_ctrl_r[dmr_pkg::BIT_REPAIR_ENTRY];
         self_refresh_abort_o <= temp_ctrl_r[dmr_pkg::BIT_SELF_REFRESH_ABORT];
         thermal_offset_o <= temp_ctrl_r[6:5];
         refresh_rate_o <= rate_r;
         temp_update_flag_o <= temp_update_flag_r;
         over_85_o <= rate_r[2];
         unsafe_temp_o <= (rate_r == dmr_pkg::RATE_LOW_LIMIT) || (rate_r == dmr_pkg::RATE_HIGH_LIMIT);
      end
   end
endmodule

// File: tb/dmr_regs_asserts.sv
`timescale 1ns/100ps
// -------------------------------------------
// mode register bank checker
// -------------------------------------------
module dmr_regs_asserts #(
   parameter logic [7:0] VENDOR_ID = 8'h5A // arbitrary value
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // command port
   input wire logic [1:0] cmd_i,
   input wire logic [5:0] addr_i,
   input wire logic [7:0] rdata_o,
   input wire logic rvalid_o,
   // sensor and precharge
   input wire logic init_done_i,
   input wire logic sensor_derate_i,
   input wire logic rd_ap_i,
   input wire logic wr_ap_i,
   input wire logic burst32_i,
   input wire logic precharge_o,
   // status
   input wire logic [4:0] read_to_precharge_clocks_o,
   input wire logic [5:0] write_recovery_clocks_o,
   input wire logic repair_protect_o,
   input wire logic [2:0] refresh_rate_o,
   input wire logic over_85_o,
   input wire logic unsafe_temp_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // cycle with no auto precharge request
   sequence s_quiet;
      !rd_ap_i && !wr_ap_i;
   endsequence
   // read with auto precharge at the reset count of eight clocks
   sequence s_rd_start;
      rd_ap_i && read_to_precharge_clocks_o == 5'h08;
   endsequence
   chk_read_answer: assert property (cmd_i == dmr_pkg::DMR_CMD_READ |=> rvalid_o)
      else $error("read not answered");
   chk_no_stray_valid: assert property (cmd_i != dmr_pkg::DMR_CMD_READ |=> !rvalid_o)
      else $error("read data valid without read");
   chk_vendor_read: assert property (cmd_i == dmr_pkg::DMR_CMD_READ && addr_i == dmr_pkg::ADDR_VENDOR_IDENTITY
      |=> rdata_o == VENDOR_ID) else $error("identity read wrong");
   chk_rtp_count: assert property (s_rd_start ##0 !burst32_i ##1 s_quiet [*7] |=> precharge_o)
      else $error("read precharge not after eight clocks");
   chk_bl32_extra: assert property (s_rd_start ##0 burst32_i ##1 s_quiet [*8] ##1 s_quiet [*7]
      |=> precharge_o) else $error("long burst precharge late");
   chk_wr_recovery: assert property (wr_ap_i && !rd_ap_i && write_recovery_clocks_o == 6'h06 ##1 s_quiet [*5]
      |=> precharge_o) else $error("write precharge not after six clocks");
   chk_protect_sticky: assert property (repair_protect_o |=> repair_protect_o)
      else $error("repair protection dropped");
   chk_over_85: assert property (over_85_o == refresh_rate_o[2])
      else $error("over temperature flag wrong");
   chk_unsafe_code: assert property (unsafe_temp_o == (refresh_rate_o == 3'h0 || refresh_rate_o == 3'h7))
      else $error("unsafe temperature flag wrong");
   chk_derate_code: assert property ((init_done_i && sensor_derate_i) [*2] |-> ##1 refresh_rate_o == 3'h6)
      else $error("derating code not reported");
endmodule
bind dmr_regs dmr_regs_asserts #(.VENDOR_ID(VENDOR_ID)) dmr_regs_asserts_inst (.*);

// File: tb/dmr_ctrl_model.sv
`timescale 1ns/100ps
// -------------------------------------------
// controller side: mode register commands
// -------------------------------------------
module dmr_ctrl_model (
   // clock
   input wire logic clk_i,
   // command port
   output logic [1:0] cmd_o,
   output logic [5:0] addr_o,
   output logic [7:0] wdata_o,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i
);
   // idle bus, clock kept at 125 MHz inside the lowest band
   initial begin
      cmd_o = 2'h0;
      addr_o = 6'h00;
      wdata_o = 8'h00;
   end
   // one write command, data driven inverted once the command cycle ends
   task automatic mr_wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cmd_o <= dmr_pkg::DMR_CMD_WRITE;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      cmd_o <= dmr_pkg::DMR_CMD_NONE;
      wdata_o <= ~d;
   endtask
   // one read command, data taken with the valid pulse
   task automatic mr_rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      @(posedge clk_i);
      cmd_o <= dmr_pkg::DMR_CMD_READ;
      addr_o <= a;
      @(posedge clk_i);
      cmd_o <= dmr_pkg::DMR_CMD_NONE;
      addr_o <= ~a;
      for (int k = 0; k < 3 && !ok; k++) begin
         #1;
         if (rvalid_i === 1'b1) begin
            d = rdata_i;
            ok = 1'b1;
         end
         else @(posedge clk_i);
      end
   endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   // -------------------------------------------
   // signals and instances
   // -------------------------------------------
   localparam logic [7:0] VID = 8'hA6; // arbitrary value
   localparam logic [5:0] A_IO = dmr_pkg::ADDR_IO_CONFIG_ONE;
   localparam logic [5:0] A_TMP = dmr_pkg::ADDR_TEMPERATURE_REFRESH;
   localparam logic [5:0] A_SP = dmr_pkg::ADDR_SET_POINT;
   logic clk_i, reset_n_i, init_done_i, sensor_derate_i, rd_ap_i, wr_ap_i, burst32_i, ok;
   logic rvalid_o, precharge_o, repair_protect_o, repair_entry_o, self_refresh_abort_o;
   logic temp_update_flag_o, over_85_o, unsafe_temp_o;
   logic [1:0] cmd_i, thermal_offset_o;
   logic [2:0] sensor_rate_i, refresh_rate_o;
   logic [3:0] read_latency_o, write_latency_o;
   logic [4:0] read_to_precharge_clocks_o;
   logic [5:0] addr_i, write_recovery_clocks_o;
   logic [7:0] wdata_i, rdata_o, op_io_config_o, d;
   int error_cnt = 0;
   int checks = 0;
   dmr_regs #(.VENDOR_ID(VID)) dmr_regs_inst (.*);
   dmr_ctrl_model dmr_ctrl_model_inst (.clk_i(clk_i), .cmd_o(cmd_i), .addr_o(addr_i), .wdata_o(wdata_i),
      .rdata_i(rdata_o), .rvalid_i(rvalid_o));
   // free running clock
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // -------------------------------------------
   // helpers
   // -------------------------------------------
   task automatic results;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("All tests passed");
      end
      else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e, input string n);
      dmr_ctrl_model_inst.mr_rd(a, d, ok);
      if (!ok) begin
         error_cnt++;
         results();
      end
      chk(n, e, d);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      dmr_ctrl_model_inst.mr_wr(a, v);
      repeat (2) @(posedge clk_i);
   endtask
   // one auto precharge request, clocks counted up to the precharge start
   task automatic ap(input logic r, input logic b, input int n, input string s);
      int k;
      @(posedge clk_i);
      rd_ap_i <= r;
      wr_ap_i <= !r;
      burst32_i <= b;
      @(posedge clk_i);
      rd_ap_i <= 1'b0;
      wr_ap_i <= 1'b0;
      for (k = 1; k < 40; k++) begin
         #1;
         if (precharge_o === 1'b1) break;
         @(posedge clk_i);
      end
      chk(s, 8'(n), 8'(k));
      if (k == 40) results();
   endtask
   // -------------------------------------------
   // scenarios
   // -------------------------------------------
   task automatic t_defaults;
      rd(A_IO, 8'h31, "io_config");
      chk("op_io", 8'h31, op_io_config_o);
      rd(A_TMP, 8'h03, "temp_reset");
      rd(dmr_pkg::ADDR_VENDOR_IDENTITY, VID, "vendor");
      rd(6'h3F, 8'h00, "unmapped");
      chk("latency", 8'h00, {read_latency_o, write_latency_o});
      ap(1'b1, 1'b0, 8, "rtp16");
      ap(1'b1, 1'b1, 16, "rtp32");
      ap(1'b0, 1'b0, 6, "wr_recovery");
   endtask
   task automatic t_temp_write;
      wr(A_TMP, 8'hFF);
      rd(A_TMP, 8'h7B, "temp_masked");
      chk("temp_fields", 8'h0F, {4'h0, thermal_offset_o, repair_entry_o, self_refresh_abort_o});
      for (int i = 0; i < 4; i++) begin
         wr(A_TMP, {1'b0, 2'(i), 5'h00});
         chk("offset", 8'(i), 8'(thermal_offset_o));
         chk("entry_exit", 8'h00, 8'(repair_entry_o));
      end
   endtask
   task automatic t_protect;
      wr(A_IO, 8'h35);
      wr(A_TMP, 8'h10);
      chk("protect", 8'h01, 8'(repair_protect_o));
      chk("entry_blocked", 8'h00, 8'(repair_entry_o));
      wr(A_IO, 8'h31);
      wr(A_TMP, 8'h08);
      chk("sticky", 8'h03, {6'h0, repair_protect_o, self_refresh_abort_o});
   endtask
   task automatic t_set_point;
      wr(A_SP, 8'h40);
      wr(A_IO, 8'hC1);
      wr(dmr_pkg::ADDR_LATENCY, 8'h7F);
      chk("op_io_kept", 8'h31, op_io_config_o);
      rd(A_IO, 8'hC1, "io_copy");
      wr(A_SP, 8'hC0);
      chk("op_io_new", 8'hC1, op_io_config_o);
      chk("latency_inv", 8'hFF, {read_latency_o, write_latency_o});
      chk("rtp_code", 8'h10, 8'(read_to_precharge_clocks_o));
      ap(1'b1, 1'b0, 16, "rtp_long");
      wr(A_IO, 8'h81);
      chk("latency_noinv", 8'h7F, {read_latency_o, write_latency_o});
   endtask
   task automatic t_rate;
      @(posedge clk_i);
      init_done_i <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         sensor_rate_i <= 3'(i);
         repeat (4) @(posedge clk_i);
         chk("rate", 8'(i), 8'(refresh_rate_o));
         chk("over85", 8'(i / 4), 8'(over_85_o));
         chk("unsafe", 8'(i == 0 || i == 7), 8'(unsafe_temp_o));
      end
      chk("flag_set", 8'h01, 8'(temp_update_flag_o));
      rd(A_TMP, 8'h8F, "temp_changed");
      rd(A_TMP, 8'h0F, "temp_cleared");
      @(posedge clk_i);
      sensor_derate_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("derate", 8'h06, 8'(refresh_rate_o));
   endtask
   // mid-run power-on reset clears sticky protection and the update flag
   task automatic t_reset;
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      init_done_i <= 1'b0;
      sensor_derate_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      chk("protect_reset", 8'h00, 8'(repair_protect_o));
      chk("flag_reset", 8'h00, 8'(temp_update_flag_o));
      chk("rate_reset", 8'h03, 8'(refresh_rate_o));
      rd(A_TMP, 8'h03, "temp_after_reset");
   endtask
   // -------------------------------------------
   // main sequence
   // -------------------------------------------
   initial begin
      reset_n_i = 1'b0;
      init_done_i = 1'b0;
      sensor_rate_i = 3'h3;
      sensor_derate_i = 1'b0;
      rd_ap_i = 1'b0;
      wr_ap_i = 1'b0;
      burst32_i = 1'b0;
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      t_defaults();
      t_temp_write();
      t_protect();
      t_set_point();
      t_rate();
      t_reset();
      results();
   end
endmodule
